// ==== can_bus_partner.sv ====
// Partner: protocol engine model that reports bus errors as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module can_bus_partner (
   input wire logic                   ref_clk,
   output var can_err_pkg::err_evt_t  errEvt,
   output var logic                   inFastPhase
);
   initial begin
      errEvt = 6'h00;
      inFastPhase = 1'b0;
   end
   // Fast phase only spans the pulse; outside a frame it reads low
   task automatic hit(input can_err_pkg::err_evt_t e, input logic f);
      @(posedge ref_clk);
      errEvt <= e;
      inFastPhase <= f;
      @(posedge ref_clk);
      errEvt <= 6'h00;
      inFastPhase <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== can_err_pkg.sv ====
// Package: constants and carrier types of the CAN error status flags
//
// Contract
// - Fast-phase transmitted recessive read dominant sets flag
// - Fast-phase transmitted dominant read recessive sets flag
// - Fast-phase CRC mismatch sets fast CRC flag
// - Fast-phase form violation sets fast form flag
// - Fast-phase stuff violation sets fast stuff flag
// - New error while any nominal or fast error flag set sets overrun
// - Fast summary is OR of five fast flags
// - Recovery sequence detected sets bus-off recovery flag
// - Synced flag follows bus synchronisation state
// - Tx warning rising edge sets tx warning interrupt
// - Tx warning interrupt frozen during bus-off
// - Rx warning rising edge sets rx warning interrupt
// - Rx warning and nominal errors update on networking exit
// - Any-format recessive-read-dominant sets nominal flag
// - Any-format dominant-read-recessive sets nominal flag
// - Acknowledge error sets acknowledge flag
// - Received CRC failure sets nominal CRC flag
// - Fixed-format field violation sets nominal form flag
// - Stuffing violation sets nominal stuff flag
// - Tx warning high while tx count at least 96
// - Rx warning high while rx count at least 96
// - Nominal summary is OR of six nominal flags
package can_err_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] ERR1_OFFSET   = 8'h20;
   localparam logic [7:0] CTRL_OFFSET   = 8'h24;
   localparam logic [0:0] CTRL_RESET    = 1'h1;
   localparam logic [7:0] WARN_LIMIT    = 8'h60;

   // ----------------------------------------------------------------
   // Bit positions of the error flags register
   // ----------------------------------------------------------------
   localparam int BIT_FAST_REC    = 31;
   localparam int BIT_FAST_DOM    = 30;
   localparam int BIT_FAST_CRC    = 28;
   localparam int BIT_FAST_FORM   = 27;
   localparam int BIT_FAST_STUFF  = 26;
   localparam int BIT_OVERRUN     = 21;
   localparam int BIT_FAST_SUM    = 20;
   localparam int BIT_RECOVERY    = 19;
   localparam int BIT_SYNCED      = 18;
   localparam int BIT_TX_WARN_IRQ = 17;
   localparam int BIT_RX_WARN_IRQ = 16;
   localparam int BIT_NOM_LSB     = 10;
   localparam int BIT_TX_WARN     = 9;
   localparam int BIT_RX_WARN     = 8;
   localparam int BIT_BUS_OFF     = 2;
   localparam int BIT_NOM_SUM     = 1;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic bitRec;
      logic bitDom;
      logic ack;
      logic crc;
      logic form;
      logic stuff;
   } err_evt_t;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADDR_W-1:0] adr;
      logic [3:0]        sel;
      logic [31:0]       dat;
   } wb_req_t;

endpackage

// ==== can_error_status_flags.sv ====
// Module: CAN error status flags with a classic Wishbone slave
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module can_error_status_flags (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire can_err_pkg::wb_req_t wbReq,
   output logic [31:0]               wbDatO,
   output logic                      wbAckO,
   input  wire can_err_pkg::err_evt_t errEvt,
   input  wire logic                 inFastPhase,
   input  wire logic                 recoverySeen,
   input  wire logic                 busSynced,
   input  wire logic                 busOff,
   input  wire logic                 pnMode,
   input  wire logic [7:0]           tx_error_count,
   input  wire logic [7:0]           rx_error_count
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Set wins over clear, so an event in the clearing cycle stays
   function automatic logic [5:0] setClr(
      input logic [5:0] cur,
      input logic [5:0] set,
      input logic [5:0] clr
   );
      setClr = set | (cur & ~clr);
   endfunction

   // Same rule for the five fast flags
   function automatic logic [4:0] setClr5(
      input logic [4:0] cur,
      input logic [4:0] set,
      input logic [4:0] clr
   );
      setClr5 = set | (cur & ~clr);
   endfunction

   function automatic logic atLimit(input logic [7:0] cnt);
      atLimit = (cnt >= can_err_pkg::WARN_LIMIT);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [5:0]  nom_q;
   logic [5:0]  nom_d;
   logic [5:0]  pend_q;
   logic [5:0]  pend_d;
   logic [4:0]  fast_q;
   logic [4:0]  fast_d;
   logic        overrun_q;
   logic        overrun_d;
   logic        recov_q;
   logic        recov_d;
   logic        synced_q;
   logic        synced_d;
   logic        txWarn_q;
   logic        txWarn_d;
   logic        rxWarn_q;
   logic        rxWarn_d;
   logic        txIrq_q;
   logic        txIrq_d;
   logic        rxIrq_q;
   logic        rxIrq_d;
   logic        pnMode_q;
   logic        pnMode_d;
   logic        latchEn_q;
   logic        latchEn_d;
   logic        ack_q;
   logic        ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic       req;
   logic       hitErr;
   logic       hitCtrl;
   logic       rdErr;
   logic       wrErr;
   logic       wrCtrl;
   logic [31:0] w1c;

   always_comb begin
      req     = wbReq.cyc & wbReq.stb & ~ack_q;
      hitErr  = (wbReq.adr == can_err_pkg::ERR1_OFFSET);
      hitCtrl = (wbReq.adr == can_err_pkg::CTRL_OFFSET);
      rdErr   = req & ~wbReq.we & hitErr;
      wrErr   = req & wbReq.we & hitErr;
      wrCtrl  = req & wbReq.we & hitCtrl & wbReq.sel[0];
      w1c     = 32'h0000_0000;
      if (wrErr & wbReq.sel[2]) begin
         w1c[23:16] = wbReq.dat[23:16];
      end
   end

   // ----------------------------------------------------------------
   // Event qualification
   // ----------------------------------------------------------------
   logic [5:0] nomEvt;
   logic [5:0] nomSet;
   logic [4:0] fastSet;
   logic       pnExit;
   logic       anyNew;
   logic       anyFlag;

   always_comb begin
      nomEvt = errEvt & {6{latchEn_q}};
      fastSet = {nomEvt[5], nomEvt[4], nomEvt[2], nomEvt[1], nomEvt[0]}
              & {5{inFastPhase}};
      pnExit = pnMode_q & ~pnMode;
      // Nominal errors seen while in networking mode wait for its exit
      if (pnMode) begin
         nomSet = 6'h00;
      end else if (pnExit) begin
         nomSet = nomEvt | pend_q;
      end else begin
         nomSet = nomEvt;
      end
      anyNew  = (|nomSet) | (|fastSet);
      anyFlag = (|nom_q) | (|fast_q);
   end

   // ----------------------------------------------------------------
   // Flag next state
   // ----------------------------------------------------------------
   logic [5:0] rdClr6;

   always_comb begin
      rdClr6   = {6{rdErr}};
      pnMode_d = pnMode;
      pend_d   = pnMode ? (pend_q | nomEvt) : 6'h00;
      nom_d    = setClr(nom_q, nomSet, rdClr6);
      fast_d   = setClr5(fast_q, fastSet, rdClr6[4:0]);
      overrun_d = (anyNew & anyFlag)
                | (overrun_q & ~w1c[can_err_pkg::BIT_OVERRUN]);
      recov_d   = (recoverySeen & latchEn_q)
                | (recov_q & ~w1c[can_err_pkg::BIT_RECOVERY]);
      synced_d  = busSynced;
      txWarn_d  = atLimit(tx_error_count);
      rxWarn_d  = pnMode ? rxWarn_q : atLimit(rx_error_count);
      if (busOff) begin
         txIrq_d = txIrq_q;
      end else begin
         txIrq_d = (txWarn_d & ~txWarn_q)
                 | (txIrq_q & ~w1c[can_err_pkg::BIT_TX_WARN_IRQ]);
      end
      rxIrq_d = (rxWarn_d & ~rxWarn_q)
              | (rxIrq_q & ~w1c[can_err_pkg::BIT_RX_WARN_IRQ]);
      latchEn_d = wrCtrl ? wbReq.dat[0] : latchEn_q;
   end

   // ----------------------------------------------------------------
   // Read data and acknowledge
   // ----------------------------------------------------------------
   logic [31:0] errWord;

   always_comb begin
      errWord = 32'h0000_0000;
      errWord[can_err_pkg::BIT_FAST_REC]    = fast_q[4];
      errWord[can_err_pkg::BIT_FAST_DOM]    = fast_q[3];
      errWord[can_err_pkg::BIT_FAST_CRC]    = fast_q[2];
      errWord[can_err_pkg::BIT_FAST_FORM]   = fast_q[1];
      errWord[can_err_pkg::BIT_FAST_STUFF]  = fast_q[0];
      errWord[can_err_pkg::BIT_OVERRUN]     = overrun_q;
      errWord[can_err_pkg::BIT_FAST_SUM]    = |fast_q;
      errWord[can_err_pkg::BIT_RECOVERY]    = recov_q;
      errWord[can_err_pkg::BIT_SYNCED]      = synced_q;
      errWord[can_err_pkg::BIT_TX_WARN_IRQ] = txIrq_q;
      errWord[can_err_pkg::BIT_RX_WARN_IRQ] = rxIrq_q;
      errWord[can_err_pkg::BIT_NOM_LSB +: 6] = nom_q;
      errWord[can_err_pkg::BIT_TX_WARN]     = txWarn_q;
      errWord[can_err_pkg::BIT_RX_WARN]     = rxWarn_q;
      errWord[can_err_pkg::BIT_BUS_OFF]     = busOff;
      errWord[can_err_pkg::BIT_NOM_SUM]     = |nom_q;
      ack_d = req;
      dat_d = 32'h0000_0000;
      // Unmapped addresses still answer, with zero data
      if (req & ~wbReq.we & hitErr) begin
         dat_d = errWord;
      end else if (req & ~wbReq.we & hitCtrl) begin
         dat_d = {31'h0000_0000, latchEn_q};
      end
   end

   // ----------------------------------------------------------------
   // Nominal error-type flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nom_q <= 6'h00;
      end else begin
         nom_q <= nom_d;
      end
   end

   // ----------------------------------------------------------------
   // Errors held back during networking mode
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_q <= 6'h00;
      end else begin
         pend_q <= pend_d;
      end
   end

   // ----------------------------------------------------------------
   // Fast-phase error flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fast_q <= 5'h00;
      end else begin
         fast_q <= fast_d;
      end
   end

   // ----------------------------------------------------------------
   // Overrun flag
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overrun_q <= 1'h0;
      end else begin
         overrun_q <= overrun_d;
      end
   end

   // ----------------------------------------------------------------
   // Recovery flag
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         recov_q <= 1'h0;
      end else begin
         recov_q <= recov_d;
      end
   end

   // ----------------------------------------------------------------
   // Synchronised flag
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         synced_q <= 1'h0;
      end else begin
         synced_q <= synced_d;
      end
   end

   // ----------------------------------------------------------------
   // Tx warning level
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txWarn_q <= 1'h0;
      end else begin
         txWarn_q <= txWarn_d;
      end
   end

   // ----------------------------------------------------------------
   // Rx warning level
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxWarn_q <= 1'h0;
      end else begin
         rxWarn_q <= rxWarn_d;
      end
   end

   // ----------------------------------------------------------------
   // Tx warning interrupt flag
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txIrq_q <= 1'h0;
      end else begin
         txIrq_q <= txIrq_d;
      end
   end

   // ----------------------------------------------------------------
   // Rx warning interrupt flag
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxIrq_q <= 1'h0;
      end else begin
         rxIrq_q <= rxIrq_d;
      end
   end

   // ----------------------------------------------------------------
   // Networking mode history, for its exit edge
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pnMode_q <= 1'h0;
      end else begin
         pnMode_q <= pnMode_d;
      end
   end

   // ----------------------------------------------------------------
   // Event latch enable control bit
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         latchEn_q <= can_err_pkg::CTRL_RESET;
      end else begin
         latchEn_q <= latchEn_d;
      end
   end

   // ----------------------------------------------------------------
   // Bus acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'h0;
      end else begin
         ack_q <= ack_d;
      end
   end

   // ----------------------------------------------------------------
   // Bus read data
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dat_q <= 32'h0000_0000;
      end else begin
         dat_q <= dat_d;
      end
   end

   assign wbAckO = ack_q;
   assign wbDatO = dat_q;

endmodule

`default_nettype wire

// ==== can_error_status_flags_asserts.sv ====
// Checker: concurrent assertions on the CAN error status flags ports
`timescale 1ns/1ps
`default_nettype none

module can_error_status_flags_asserts (
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire can_err_pkg::wb_req_t  wbReq,
   input wire logic [31:0]           wbDatO,
   input wire logic                  wbAckO,
   input wire can_err_pkg::err_evt_t errEvt,
   input wire logic                  inFastPhase,
   input wire logic                  recoverySeen,
   input wire logic                  busSynced,
   input wire logic                  busOff,
   input wire logic                  pnMode,
   input wire logic [7:0]            tx_error_count,
   input wire logic [7:0]            rx_error_count
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic rdAdr = !wbReq.we && wbReq.adr == can_err_pkg::ERR1_OFFSET;
   wire logic rd    = wbAckO && rdAdr;
   sequence s_take;
      wbReq.cyc && wbReq.stb && !wbAckO;
   endsequence
   sequence s_fastRec;
      errEvt.bitRec && inFastPhase && !pnMode;
   endsequence
   property p_ack;
      s_take |=> wbAckO ##1 !wbAckO;
   endproperty
   a_ack: assert property (p_ack) else $error("ack is not one pulse after request");
   property p_fastBit;
      s_fastRec ##1 s_take ##0 rdAdr |=> wbDatO[31] && wbDatO[15];
   endproperty
   a_fastBit: assert property (p_fastBit) else $error("fast error missing");
   property p_fastSum;
      rd |-> wbDatO[20] == |{wbDatO[31:30], wbDatO[28:26]};
   endproperty
   a_fastSum: assert property (p_fastSum) else $error("fast summary wrong");
   property p_nomSum;
      rd |-> wbDatO[1] == |wbDatO[15:10];
   endproperty
   a_nomSum: assert property (p_nomSum) else $error("nominal summary wrong");
   property p_txWarn;
      rd && $past(tx_error_count) == $past(tx_error_count, 2)
         |-> wbDatO[9] == ($past(tx_error_count) >= can_err_pkg::WARN_LIMIT);
   endproperty
   a_txWarn: assert property (p_txWarn) else $error("tx warning wrong");
   property p_rxWarn;
      rd && !$past(pnMode) && !$past(pnMode, 2) && $past(rx_error_count) == $past(rx_error_count, 2)
         |-> wbDatO[8] == ($past(rx_error_count) >= can_err_pkg::WARN_LIMIT);
   endproperty
   a_rxWarn: assert property (p_rxWarn) else $error("rx warning wrong");
   property p_synced;
      rd && $past(busSynced) == $past(busSynced, 2) |-> wbDatO[18] == $past(busSynced);
   endproperty
   a_synced: assert property (p_synced) else $error("synced flag wrong");
   // Idle data must be zero so a stray flag cannot leak onto the bus
   property p_idle;
      !wbAckO |-> wbDatO == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("read data not zero outside ack");
endmodule

bind can_error_status_flags can_error_status_flags_asserts chk (.ref_clk, .rst, .wbReq, .wbDatO,
   .wbAckO, .errEvt, .inFastPhase, .recoverySeen, .busSynced, .busOff, .pnMode, .tx_error_count,
   .rx_error_count);
`default_nettype wire

// ==== test_can_error_status_flags.sv ====
// Testbench: self-checking bench for the CAN error status flags
`timescale 1ns/1ps
`default_nettype none

module test_can_error_status_flags;
   logic                  ref_clk;
   logic                  rst;
   can_err_pkg::wb_req_t  wbReq;
   logic [31:0]           wbDatO;
   logic                  wbAckO;
   can_err_pkg::err_evt_t errEvt;
   logic                  inFastPhase;
   logic                  recoverySeen;
   logic                  busSynced;
   logic                  busOff;
   logic                  pnMode;
   logic [7:0]            txCnt;
   logic [7:0]            rxCnt;
   int                    failures;
   int                    n_tests;
   logic [31:0]           v;
   can_err_pkg::err_evt_t e;
   logic                  f;

   can_error_status_flags dut (.ref_clk, .rst, .wbReq, .wbDatO, .wbAckO, .errEvt, .inFastPhase,
      .recoverySeen, .busSynced, .busOff, .pnMode, .tx_error_count(txCnt), .rx_error_count(rxCnt));
   can_bus_partner partner (.ref_clk, .errEvt, .inFastPhase);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Waits on ack with a bound so a dead slave cannot hang the run
   task automatic wbAcc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int k;
      k = 0;
      @(posedge ref_clk);
      wbReq <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
      do begin
         @(posedge ref_clk);
         k++;
      end while (wbAckO !== 1'b1 && k < 20);
      v = wbDatO;
      wbReq <= '0;
      if (k >= 20) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic rdf();
      wbAcc(1'b0, can_err_pkg::ERR1_OFFSET, 32'h0);
   endtask
   function automatic logic [31:0] errBits(input can_err_pkg::err_evt_t x, input logic fast);
      logic [31:0] r;
      r = 32'h0;
      r[15:10] = x;
      if (fast) begin
         r[31:30] = x[5:4];
         r[28:26] = x[2:0];
      end
      r[20] = |{r[31:30], r[28:26]};
      r[1] = |r[15:10];
      return r;
   endfunction
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      tick(5000);
      failures++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      n_tests = 0;
      rst = 1'b1;
      wbReq = '0;
      recoverySeen = 1'b0;
      busSynced = 1'b0;
      busOff = 1'b0;
      pnMode = 1'b0;
      txCnt = 8'h00;
      rxCnt = 8'h00;
      v = $urandom(32'h556F);
      tick(12);
      rst <= 1'b0;
      rdf();
      check(v, 32'h0);
      wbAcc(1'b0, 8'h3C, 32'h0);
      check(v, 32'h0);
      // Single fast codes first, then random mixes; read lands one edge after the event
      for (int i = 0; i < 14; i++) begin
         e = (i < 6) ? 6'h01 << i : 6'($urandom);
         f = (i < 6) | 1'($urandom);
         fork
            partner.hit(e, f);
            begin
               tick(1);
               rdf();
            end
         join
         check(v & 32'hDC10FC02, errBits(e, f));
         rdf();
         check(v & 32'hDC10FC02, 32'h0);
      end
      partner.hit(6'h10, 1'b0);
      partner.hit(6'h04, 1'b0);
      rdf();
      check(v & 32'h0020FC02, 32'h00205002);
      wbAcc(1'b1, can_err_pkg::ERR1_OFFSET, 32'h00200000);
      rdf();
      check(v & 32'h00200000, 32'h0);
      txCnt <= 8'h5F;
      rxCnt <= 8'h5F;
      tick(3);
      rdf();
      check(v & 32'h00030300, 32'h0);
      txCnt <= 8'h60;
      rxCnt <= 8'h60;
      tick(3);
      rdf();
      check(v & 32'h00030300, 32'h00030300);
      wbAcc(1'b1, can_err_pkg::ERR1_OFFSET, 32'h00030000);
      rdf();
      check(v & 32'h00030300, 32'h00000300);
      txCnt <= 8'h00;
      rxCnt <= 8'h00;
      busOff <= 1'b1;
      tick(3);
      txCnt <= 8'h60;
      tick(3);
      rdf();
      check(v & 32'h00020204, 32'h00000204);
      busOff <= 1'b0;
      pnMode <= 1'b1;
      tick(1);
      rxCnt <= 8'h60;
      partner.hit(6'h08, 1'b0);
      rdf();
      check(v & 32'h00012100, 32'h0);
      pnMode <= 1'b0;
      tick(3);
      rdf();
      check(v & 32'h00012100, 32'h00012100);
      recoverySeen <= 1'b1;
      busSynced <= 1'b1;
      tick(1);
      recoverySeen <= 1'b0;
      tick(2);
      rdf();
      check(v & 32'h000C0000, 32'h000C0000);
      wbAcc(1'b1, can_err_pkg::ERR1_OFFSET, 32'h00080000);
      rdf();
      check(v & 32'h000C0000, 32'h00040000);
      wbAcc(1'b1, can_err_pkg::CTRL_OFFSET, 32'h0);
      wbAcc(1'b0, can_err_pkg::CTRL_OFFSET, 32'h0);
      check(v, 32'h0);
      partner.hit(6'h3F, 1'b1);
      rdf();
      check(v & 32'hDC10FC02, 32'h0);
      wbAcc(1'b1, 8'h3C, 32'h0);
      wbAcc(1'b1, can_err_pkg::CTRL_OFFSET, 32'h1);
      wbAcc(1'b0, can_err_pkg::CTRL_OFFSET, 32'h0);
      check(v, 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
